// ==== logic/kpc_keypad_ctrl.sv ====
`timescale 1ns/1ps
`include "kpc_regs.svh"

module kpc_keypad_ctrl #(
  parameter int DEB_CYC = `KPC_DEBOUNCE_CYC,
  parameter int HELP_CYC = `KPC_HELP_MSG_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Keypad and drive status
  input wire kpc_pkg::kpc_keys_t keys_raw,
  input wire logic fault_in,
  input wire logic at_zero_speed,
  // Drive command, display, interrupt
  output kpc_pkg::kpc_drive_cmd_t drive_cmd,
  output logic fault_reset,
  output kpc_pkg::kpc_disp_t disp,
  output logic irq
);
  localparam int NK = $bits(kpc_pkg::kpc_keys_t);
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int HW = $clog2(HELP_CYC + 1);

  // ==========================================================
  // Key debounce
  logic [NK-1:0] raw_vec;
  logic [NK-1:0] stable_vec;
  logic [NK-1:0] stable_d;
  kpc_pkg::kpc_keys_t lvl;
  kpc_pkg::kpc_keys_t press;
  assign raw_vec = keys_raw;

  genvar gi;
  generate
    for (gi = 0; gi < NK; gi++) begin : g_deb
      logic [DW-1:0] cnt;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          cnt <= '0;
          stable_vec[gi] <= 1'b0;
        end else if (raw_vec[gi] == stable_vec[gi]) begin
          cnt <= '0;
        end else if (cnt == DW'(DEB_CYC - 1)) begin
          cnt <= '0;
          stable_vec[gi] <= raw_vec[gi];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  endgenerate

  // Delayed copy for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stable_d <= '0;
    end else begin
      stable_d <= stable_vec;
    end
  end
  assign press = stable_vec & ~stable_d;
  assign lvl = stable_vec;

  // ==========================================================
  // Configuration registers
  logic rev_perm;
  logic [1:0] stop_method;
  logic [15:0] min_speed;
  logic [15:0] max_speed;
  logic [15:0] jog_speed;
  logic [15:0] jog_accel;
  logic [15:0] jog_decel;
  logic [`KPC_NUM_EV-1:0] int_stat;
  logic [`KPC_NUM_EV-1:0] int_mask;
  logic wr_en;
  logic rd_setup;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // Software writes take effect at the access edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rev_perm <= 1'b0;
      stop_method <= 2'h0;
      min_speed <= `KPC_RST_MIN;
      max_speed <= `KPC_RST_MAX;
      jog_speed <= `KPC_RST_JOG;
      jog_accel <= `KPC_RST_JOGRATE;
      jog_decel <= `KPC_RST_JOGRATE;
      int_mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        `KPC_OFS_CTRL: begin
          rev_perm <= pwdata[`KPC_CTRL_REVPERM];
          stop_method <= pwdata[`KPC_CTRL_STOPM_HI:`KPC_CTRL_STOPM_LO];
        end
        `KPC_OFS_MIN: min_speed <= pwdata[15:0];
        `KPC_OFS_MAX: max_speed <= pwdata[15:0];
        `KPC_OFS_JOG: jog_speed <= pwdata[15:0];
        `KPC_OFS_JOGRATE: begin
          jog_accel <= pwdata[15:0];
          jog_decel <= pwdata[31:16];
        end
        `KPC_OFS_INTMASK: int_mask <= pwdata[`KPC_NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Run / direction state machine
  kpc_pkg::kpc_run_t state;
  logic turn_to_rev;
  logic jog_mode;
  logic want_fwd;
  logic want_rev;
  // In jog the run keys act as levels, otherwise as press edges
  // hold-to-run in jog
  assign want_fwd = jog_mode ? lvl.fwd : press.fwd;
  assign want_rev = rev_perm && (jog_mode ? lvl.rev : press.rev);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= kpc_pkg::ST_STOP;
      turn_to_rev <= 1'b0;
    end else begin
      case (state)
        kpc_pkg::ST_STOP: begin
          if (want_fwd && !press.stop) begin
            state <= kpc_pkg::ST_FWD;
          end else if (want_rev && !press.stop) begin
            state <= kpc_pkg::ST_REV;
          end
        end
        kpc_pkg::ST_FWD: begin
          if (press.stop) begin
            state <= kpc_pkg::ST_STOP;
          end else if (jog_mode && !lvl.fwd) begin
            state <= kpc_pkg::ST_STOP;
          end else if (!jog_mode && want_rev) begin
            state <= kpc_pkg::ST_TURN;
            turn_to_rev <= 1'b1;
          end
        end
        kpc_pkg::ST_REV: begin
          if (press.stop) begin
            state <= kpc_pkg::ST_STOP;
          end else if (jog_mode && !lvl.rev) begin
            state <= kpc_pkg::ST_STOP;
          end else if (!jog_mode && rev_perm && press.fwd) begin
            state <= kpc_pkg::ST_TURN;
            turn_to_rev <= 1'b0;
          end
        end
        kpc_pkg::ST_TURN: begin
          if (press.stop) begin
            state <= kpc_pkg::ST_STOP;
          end else if (at_zero_speed) begin
            state <= turn_to_rev ? kpc_pkg::ST_REV : kpc_pkg::ST_FWD;
          end
        end
        default: state <= kpc_pkg::ST_STOP;
      endcase
    end
  end

  // jog entry only when stopped, toggled by the key
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      jog_mode <= 1'b0;
    end else if (press.jog && state == kpc_pkg::ST_STOP) begin
      jog_mode <= !jog_mode;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= press.stop && fault_in;
    end
  end

  // ==========================================================
  // Digital setpoint
  logic [15:0] setpt;
  logic [16:0] step;
  logic [16:0] sum;
  logic up_op;
  logic dn_op;
  logic [15:0] next_setpt;
  logic limited;
  assign step = (press.up100 || press.dn100) ? `KPC_STEP_COARSE : `KPC_STEP_FINE;
  assign up_op = press.up1 || press.up100;
  assign dn_op = !up_op && (press.dn1 || press.dn100);
  assign sum = {1'b0, setpt} + step;

  // Saturating step; limited flags a press that hit a bound
  always_comb begin
    next_setpt = setpt;
    limited = 1'b0;
    if (up_op) begin
      if (sum > {1'b0, max_speed}) begin
        next_setpt = max_speed;
        limited = 1'b1;
      end else begin
        next_setpt = sum[15:0];
      end
    end else if (dn_op) begin
      if ({1'b0, setpt} < {1'b0, min_speed} + step) begin
        next_setpt = min_speed;
        limited = 1'b1;
      end else begin
        next_setpt = setpt - step[15:0];
      end
    end
  end

  // setpoint steps apply stopped or running
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      setpt <= `KPC_RST_SETPT;
    end else begin
      setpt <= next_setpt;
    end
  end

  // ==========================================================
  // Command outputs, registered; speed follows setpoint in FWD/REV (zero in TURN), or jog_speed in jog mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drive_cmd <= '0;
    end else begin
      drive_cmd.run <= (state != kpc_pkg::ST_STOP);
      drive_cmd.dir_rev <= (state == kpc_pkg::ST_REV) || (state == kpc_pkg::ST_TURN && !turn_to_rev);
      // stop method passed to the ramp
      drive_cmd.stop_method <= stop_method;
      if (jog_mode) begin
        drive_cmd.speed_ref <= (state == kpc_pkg::ST_STOP) ? 16'h0000 : jog_speed;
        drive_cmd.accel_rate <= jog_accel;
        drive_cmd.decel_rate <= jog_decel;
      end else begin
        drive_cmd.speed_ref <= (state == kpc_pkg::ST_FWD || state == kpc_pkg::ST_REV) ? setpt : 16'h0000;
        drive_cmd.accel_rate <= 16'h0000;
        drive_cmd.decel_rate <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // Display: status window, jog flag, help sequence
  logic [HW-1:0] help_cnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disp.window <= 2'h0;
      disp.jog_ind <= 1'b0;
    end else begin
      // next window, wraps after the fourth
      if (press.status) begin
        disp.window <= disp.window + 2'h1;
      end
      disp.jog_ind <= jog_mode;
    end
  end

  // help messages sequenced by a timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      disp.help_msg <= kpc_pkg::HELP_OFF;
      help_cnt <= '0;
    end else if (press.help) begin
      disp.help_msg <= kpc_pkg::HELP_MSG1;
      help_cnt <= '0;
    end else if (disp.help_msg != kpc_pkg::HELP_OFF) begin
      if (help_cnt == HW'(HELP_CYC - 1)) begin
        help_cnt <= '0;
        case (disp.help_msg)
          kpc_pkg::HELP_MSG1: disp.help_msg <= kpc_pkg::HELP_MSG2;
          kpc_pkg::HELP_MSG2: disp.help_msg <= fault_in ? kpc_pkg::HELP_FAULT : kpc_pkg::HELP_OFF;
          default: disp.help_msg <= kpc_pkg::HELP_OFF;
        endcase
      end else begin
        help_cnt <= help_cnt + 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupt status: set wins over a same-cycle write-one clear
  logic [`KPC_NUM_EV-1:0] ev;
  logic [`KPC_NUM_EV-1:0] clr;
  kpc_pkg::kpc_run_t state_d;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_d <= kpc_pkg::ST_STOP;
    end else begin
      state_d <= state;
    end
  end
  assign ev[`KPC_EV_KEY] = |press;
  assign ev[`KPC_EV_START] = state_d == kpc_pkg::ST_STOP && state != kpc_pkg::ST_STOP;
  assign ev[`KPC_EV_STOPPED] = state_d != kpc_pkg::ST_STOP && state == kpc_pkg::ST_STOP;
  assign ev[`KPC_EV_FAULTCLR] = fault_reset;
  assign ev[`KPC_EV_LIMIT] = limited;
  assign clr = (wr_en && paddr == `KPC_OFS_INTSTAT) ? pwdata[`KPC_NUM_EV-1:0] : '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~clr) | ev;
    end
  end
  assign irq = |(int_stat & int_mask);

  // ==========================================================
  // APB read path: data captured in setup, zero wait states
  logic mapped;
  always_comb begin
    case (paddr)
      `KPC_OFS_CTRL, `KPC_OFS_MIN, `KPC_OFS_MAX, `KPC_OFS_SETPT, `KPC_OFS_JOG,
      `KPC_OFS_JOGRATE, `KPC_OFS_STATE, `KPC_OFS_INTSTAT, `KPC_OFS_INTMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        `KPC_OFS_CTRL: prdata <= {29'h0, stop_method, rev_perm};
        `KPC_OFS_MIN: prdata <= {16'h0000, min_speed};
        `KPC_OFS_MAX: prdata <= {16'h0000, max_speed};
        `KPC_OFS_SETPT: prdata <= {16'h0000, setpt};
        `KPC_OFS_JOG: prdata <= {16'h0000, jog_speed};
        `KPC_OFS_JOGRATE: prdata <= {jog_decel, jog_accel};
        `KPC_OFS_STATE: prdata <= {24'h0, fault_in, disp.help_msg, disp.window, jog_mode, state};
        `KPC_OFS_INTSTAT: prdata <= {27'h0, int_stat};
        `KPC_OFS_INTMASK: prdata <= {27'h0, int_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // Checks
  AST_FWD_START: assert property (@(posedge ref_clk) disable iff (rst)
    state == kpc_pkg::ST_STOP && !jog_mode && press.fwd && !press.stop |=> state == kpc_pkg::ST_FWD)
    else $error("forward press did not start drive");
  AST_TURN_FWD: assert property (@(posedge ref_clk) disable iff (rst)
    state == kpc_pkg::ST_REV && !jog_mode && rev_perm && press.fwd && !press.stop
    |=> state == kpc_pkg::ST_TURN ##1 drive_cmd.speed_ref == 16'h0000)
    else $error("reversal to forward did not pass through zero");
  AST_REV_START: assert property (@(posedge ref_clk) disable iff (rst)
    state == kpc_pkg::ST_STOP && !jog_mode && rev_perm && press.rev && !press.fwd && !press.stop
    |=> state == kpc_pkg::ST_REV ##1 drive_cmd.dir_rev)
    else $error("reverse press did not start reverse");
  AST_REV_BLOCKED: assert property (@(posedge ref_clk) disable iff (rst)
    !rev_perm && state == kpc_pkg::ST_FWD && !jog_mode && press.rev |=> state != kpc_pkg::ST_TURN)
    else $error("reverse key acted without permission");
  AST_JOG_ENTER: assert property (@(posedge ref_clk) disable iff (rst)
    state != kpc_pkg::ST_STOP && press.jog |=> jog_mode == $past(jog_mode))
    else $error("jog mode changed while running");
  AST_JOG_SPEED: assert property (@(posedge ref_clk) disable iff (rst)
    jog_mode && state == kpc_pkg::ST_FWD ##1 jog_mode |-> drive_cmd.speed_ref == jog_speed)
    else $error("jog run not at jog speed");
  AST_JOG_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    jog_mode && state == kpc_pkg::ST_FWD && !lvl.fwd |=> state == kpc_pkg::ST_STOP)
    else $error("jog kept running after key release");
  AST_STOP: assert property (@(posedge ref_clk) disable iff (rst)
    press.stop |=> state == kpc_pkg::ST_STOP ##1 !drive_cmd.run)
    else $error("stop key did not stop drive");
  AST_FAULT_CLR: assert property (@(posedge ref_clk) disable iff (rst)
    press.stop && fault_in |=> fault_reset ##1 !fault_reset || $past(press.stop))
    else $error("stop did not clear fault");
  AST_SP_MAX: assert property (@(posedge ref_clk) disable iff (rst)
    up_op && setpt <= max_speed |=> setpt <= max_speed)
    else $error("setpoint passed maximum");
  AST_SP_STEP: assert property (@(posedge ref_clk) disable iff (rst)
    press.up100 && {1'b0, setpt} + 17'h0_0064 <= {1'b0, max_speed} |=> setpt == $past(setpt) + 16'h0064)
    else $error("coarse step not one hundred");
  AST_WIN_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    press.status && disp.window == 2'h3 |=> disp.window == 2'h0)
    else $error("status window did not wrap");
  AST_HELP: assert property (@(posedge ref_clk) disable iff (rst)
    press.help |=> disp.help_msg == kpc_pkg::HELP_MSG1)
    else $error("help did not show first message");
  COV_TURN: cover property (@(posedge ref_clk) disable iff (rst)
    state == kpc_pkg::ST_TURN ##[1:1000] state == kpc_pkg::ST_FWD);
  COV_JOG: cover property (@(posedge ref_clk) disable iff (rst)
    jog_mode && state == kpc_pkg::ST_REV);
  COV_FAULT: cover property (@(posedge ref_clk) disable iff (rst) fault_reset);
  COV_HELP: cover property (@(posedge ref_clk) disable iff (rst) disp.help_msg == kpc_pkg::HELP_FAULT);
endmodule

// ==== include/kpc_regs.svh ====
`ifndef KPC_REGS_SVH
`define KPC_REGS_SVH
// ==========================================================
// Register offsets (byte addresses)
`define KPC_OFS_CTRL 12'h000
`define KPC_OFS_MIN 12'h004
`define KPC_OFS_MAX 12'h008
`define KPC_OFS_SETPT 12'h00C
`define KPC_OFS_JOG 12'h010
`define KPC_OFS_JOGRATE 12'h014
`define KPC_OFS_STATE 12'h018
`define KPC_OFS_INTSTAT 12'h01C
`define KPC_OFS_INTMASK 12'h020
// ==========================================================
// Field positions
`define KPC_CTRL_REVPERM 0
`define KPC_CTRL_STOPM_LO 1
`define KPC_CTRL_STOPM_HI 2
`define KPC_EV_KEY 0
`define KPC_EV_START 1
`define KPC_EV_STOPPED 2
`define KPC_EV_FAULTCLR 3
`define KPC_EV_LIMIT 4
`define KPC_NUM_EV 5
// ==========================================================
// Reset values and setpoint step sizes
`define KPC_RST_MIN 16'h0000
`define KPC_RST_MAX 16'h0708
`define KPC_RST_SETPT 16'h0000
`define KPC_RST_JOG 16'h0064
`define KPC_RST_JOGRATE 16'h001E
`define KPC_STEP_FINE 17'h0_0001
`define KPC_STEP_COARSE 17'h0_0064
// ==========================================================
// Timing
`define KPC_CLK_MHZ 200
`define KPC_DEBOUNCE_US 10000
`define KPC_HELP_MSG_US 1000000
`define KPC_DEBOUNCE_CYC (`KPC_DEBOUNCE_US * `KPC_CLK_MHZ)
`define KPC_HELP_MSG_CYC (`KPC_HELP_MSG_US * `KPC_CLK_MHZ)
`endif

// ==== include/kpc_pkg.sv ====
package kpc_pkg;
  // ==========================================================
  // Drive direction state
  typedef enum logic [1:0] {
    ST_STOP,
    ST_FWD,
    ST_REV,
    ST_TURN
  } kpc_run_t;
  // ==========================================================
  // Help message step shown on the display
  typedef enum logic [1:0] {
    HELP_OFF,
    HELP_MSG1,
    HELP_MSG2,
    HELP_FAULT
  } kpc_help_t;
  // ==========================================================
  // Keypad keys, one bit each
  typedef struct packed {
    logic help;
    logic status;
    logic dn100;
    logic dn1;
    logic up100;
    logic up1;
    logic stop;
    logic jog;
    logic rev;
    logic fwd;
  } kpc_keys_t;
  // ==========================================================
  // Command bundle toward the ramp generator
  typedef struct packed {
    logic run;
    logic dir_rev;
    logic [1:0] stop_method;
    logic [15:0] speed_ref;
    logic [15:0] accel_rate;
    logic [15:0] decel_rate;
  } kpc_drive_cmd_t;
  // ==========================================================
  // Display bundle
  typedef struct packed {
    logic jog_ind;
    logic [1:0] window;
    kpc_help_t help_msg;
  } kpc_disp_t;
endpackage

// ==== dv/kpc_operator_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Operator at the keypad
module kpc_operator_model (
  // Clock
  input wire logic ref_clk,
  // Keys toward the block
  output kpc_pkg::kpc_keys_t keys_raw
);
  // All keys up at power-on
  initial begin
    keys_raw = '0;
  end
  // A finger only moves just after an edge
  task automatic hold_key(input int idx);
    @(posedge ref_clk);
    keys_raw[idx] <= 1'b1;
  endtask
  task automatic release_key(input int idx);
    @(posedge ref_clk);
    keys_raw[idx] <= 1'b0;
  endtask
  // Momentary press; a worn contact chatters before it settles
  task automatic press(input int idx, input int dwell, input bit chatter);
    if (chatter) begin
      repeat (2) begin
        hold_key(idx);
        release_key(idx);
      end
    end
    hold_key(idx);
    repeat (dwell) @(posedge ref_clk);
    release_key(idx);
    repeat (dwell) @(posedge ref_clk);
  endtask
endmodule

// ==== dv/kpc_keypad_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`include "kpc_regs.svh"
module kpc_keypad_ctrl_tb_top;
  // Short filter and help times keep the run brief
  localparam int DEB = 4;
  localparam int HLP = 8;
  localparam int DW = 12;
  localparam int LIMIT = 6000;
  localparam int K_FWD = 0, K_REV = 1, K_JOG = 2, K_STOP = 3, K_UP1 = 4;
  localparam int K_UP100 = 5, K_DN1 = 6, K_DN100 = 7, K_STAT = 8, K_HELP = 9;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic fault_in = 1'b0;
  logic at_zero_speed = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_reset;
  logic irq;
  logic [31:0] rd;
  logic err;
  kpc_pkg::kpc_keys_t keys_raw;
  kpc_pkg::kpc_drive_cmd_t drive_cmd;
  kpc_pkg::kpc_disp_t disp;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_fr = 0;
  logic [11:0] ra [7] = '{`KPC_OFS_CTRL, `KPC_OFS_MIN, `KPC_OFS_MAX, `KPC_OFS_SETPT, `KPC_OFS_JOG,
                          `KPC_OFS_JOGRATE, `KPC_OFS_INTMASK};
  logic [31:0] rv [7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0708, 32'h0000_0000, 32'h0000_0064,
                          32'h001E_001E, 32'h0000_0000};
  int sk [8] = '{K_DN1, K_UP100, K_UP1, K_DN100, K_UP100, K_UP1, K_UP1, K_DN1};
  logic [31:0] sv [8] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0065, 32'h0000_0001, 32'h0000_0065,
                          32'h0000_0066, 32'h0000_0066, 32'h0000_0065};

  kpc_keypad_ctrl #(.DEB_CYC(DEB), .HELP_CYC(HLP)) i_kpc_keypad_ctrl (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .keys_raw(keys_raw),
    .fault_in(fault_in), .at_zero_speed(at_zero_speed), .drive_cmd(drive_cmd),
    .fault_reset(fault_reset), .disp(disp), .irq(irq));
  kpc_operator_model i_kpc_operator_model (.ref_clk(ref_clk), .keys_raw(keys_raw));

  // ==========================================================
  // Clock, watchdog, pulse counter
  always #2.5 ref_clk = ~ref_clk;
  // A hang would otherwise run forever; it counts as a mismatch
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  // One-cycle pulses are easy to miss by polling, so count them here
  always @(posedge ref_clk) begin
    if (fault_reset === 1'b1) n_fr <= n_fr + 1;
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check32(rd & mask, exp);
  endtask
  task automatic cmd_chk(input logic [31:0] exp);
    check32({drive_cmd.run, drive_cmd.dir_rev, 14'h0000, drive_cmd.speed_ref}, exp);
  endtask
  task automatic irq_chk(input logic [31:0] exp);
    @(posedge ref_clk);
    #1 check32(32'(irq), exp);
  endtask
  task automatic wait_help(input logic [1:0] v);
    int n = 0;
    while (disp.help_msg !== v && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    check32(32'(disp.help_msg), 32'(v));
  endtask
  task automatic push(input int k, input bit chatter = 1'b0);
    i_kpc_operator_model.press(k, DW, chatter);
  endtask
  task automatic settle_zero();
    at_zero_speed <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) reg_chk(ra[i], 32'hFFFF_FFFF, rv[i]);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check32({err, rd[30:0]}, 32'h8000_0000);
    $display("Test registers done");
    apb(1'b1, `KPC_OFS_MAX, 32'h0000_0066);
    for (int i = 0; i < 8; i++) begin
      push(sk[i], i == 2);
      reg_chk(`KPC_OFS_SETPT, 32'h0000_FFFF, sv[i]);
    end
    $display("Test setpoint done");
    for (int i = 1; i <= 4; i++) begin
      push(K_STAT);
      check32(32'(disp.window), 32'(i % 4));
    end
    $display("Test status done");
    push(K_JOG);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0004);
    check32(32'(disp.jog_ind), 32'h0000_0001);
    i_kpc_operator_model.hold_key(K_FWD);
    repeat (DW) @(posedge ref_clk);
    cmd_chk(32'h8000_0064);
    check32(32'(drive_cmd.accel_rate), 32'h0000_001E);
    i_kpc_operator_model.release_key(K_FWD);
    repeat (DW) @(posedge ref_clk);
    check32({drive_cmd.decel_rate, drive_cmd.speed_ref}, 32'h001E_0000);
    push(K_JOG);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0000);
    check32(32'(disp.jog_ind), 32'h0000_0000);
    $display("Test jog done");
    push(K_FWD);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0001);
    cmd_chk(32'h8000_0065);
    push(K_JOG);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0001);
    push(K_UP1);
    cmd_chk(32'h8000_0066);
    push(K_REV);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0001);
    apb(1'b1, `KPC_OFS_CTRL, 32'h0000_0001);
    push(K_REV);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0003);
    check32(32'(drive_cmd.speed_ref), 32'h0000_0000);
    settle_zero();
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0002);
    cmd_chk(32'hC000_0066);
    at_zero_speed <= 1'b0;
    push(K_FWD);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0003);
    settle_zero();
    cmd_chk(32'h8000_0066);
    at_zero_speed <= 1'b0;
    apb(1'b1, `KPC_OFS_CTRL, 32'h0000_0005);
    push(K_STOP);
    reg_chk(`KPC_OFS_STATE, 32'h0000_0007, 32'h0000_0000);
    check32({drive_cmd.run, 29'h0000_0000, drive_cmd.stop_method}, 32'h0000_0002);
    check32(n_fr, 32'h0000_0000);
    fault_in <= 1'b1;
    push(K_STOP);
    check32(n_fr, 32'h0000_0001);
    $display("Test run and stop done");
    i_kpc_operator_model.hold_key(K_HELP);
    wait_help(2'h1);
    i_kpc_operator_model.release_key(K_HELP);
    wait_help(2'h2);
    wait_help(2'h3);
    wait_help(2'h0);
    fault_in <= 1'b0;
    $display("Test help done");
    // Every event kind has fired by now: press, start, stop, fault clear, limit
    reg_chk(`KPC_OFS_INTSTAT, 32'h0000_001F, 32'h0000_001F);
    apb(1'b1, `KPC_OFS_INTSTAT, 32'h0000_001F);
    reg_chk(`KPC_OFS_INTSTAT, 32'h0000_001F, 32'h0000_0000);
    apb(1'b1, `KPC_OFS_INTMASK, 32'h0000_0001);
    irq_chk(32'h0000_0000);
    push(K_STAT);
    reg_chk(`KPC_OFS_INTSTAT, 32'h0000_0001, 32'h0000_0001);
    irq_chk(32'h0000_0001);
    apb(1'b1, `KPC_OFS_INTMASK, 32'h0000_0000);
    irq_chk(32'h0000_0000);
    apb(1'b1, `KPC_OFS_INTMASK, 32'h0000_0001);
    apb(1'b1, `KPC_OFS_INTSTAT, 32'h0000_0001);
    irq_chk(32'h0000_0000);
    $display("Test interrupt done");
    report_and_stop();
  end
endmodule
